/* octal_port_pkg.sv */
// Package for the octal converter parallel port host controller
package octal_port_pkg;
  localparam int CLK_PERIOD_NS   = 8;
  localparam int DATA_W          = 12;
  localparam int ADDR_W          = 5;
  // Pin timing figures in ns
  localparam int CS_WR_MIN_NS    = 35;
  localparam int CS_RD_MIN_NS    = 60;
  localparam int SETUP_MIN_NS    = 12;
  localparam int HOLD_MIN_NS     = 5;
  localparam int RD_VALID_MAX_NS = 50;
  localparam int LOAD_PULSE_NS   = 10;
  localparam int CS_TO_LOAD_NS   = 30;
  localparam int SAME_ADDR_NS    = 30;
  localparam int BUSY_FALL_NS    = 20;
  // Least times round up
  localparam int CS_WR_CYC   = (CS_WR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_RD_CYC   = (CS_RD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC   = (SETUP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC    = (HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_CYC    = (LOAD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_LOAD_CYC = (CS_TO_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAME_CYC    = (SAME_ADDR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_CYC    = (BUSY_FALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W       = 4;
  // Own command registers, word indices
  localparam logic [3:0] REG_ADDR    = 4'h0;
  localparam logic [3:0] REG_WDATA   = 4'h1;
  localparam logic [3:0] REG_CTRL    = 4'h2;
  localparam logic [3:0] REG_STATUS  = 4'h3;
  localparam logic [3:0] REG_RDATA   = 4'h4;
  // Control register fields
  localparam int CTRL_GO_BIT   = 0;
  localparam int CTRL_READ_BIT = 1;
  localparam int CTRL_SYNC_BIT = 2;
  localparam int CTRL_CORR_BIT = 3;
  localparam int CTRL_LOAD_BIT = 4;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    SEQ_DIRECT,
    SEQ_SYNC,
    SEQ_SYNC_CORR
  } seq_e;

  // Device-side pins driven by the host
  typedef struct packed {
    logic              rd_not_wr;
    logic              chip_sel_n;
    logic              load_outputs_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data_o;
    logic [DATA_W-1:0] data_oe;
  } pins_s;
endpackage

/* octal_port_host.sv */
// Host controller driving the octal converter parallel port pins
`timescale 1ns/1ps
// Parallel port interface rules, host and device side
// RULE_01: Read-not-write line high for reads, low for writes.
// RULE_02: Chip select is active low; device ignores bus while it is high.
// RULE_03: Channels 0-3 form group one, 4-7 group two (device side).
// RULE_04: Auxiliary register writes use single access, no load trigger.
// RULE_05: Load pin held low gives asynchronous mode, same single access.
// RULE_06: Sync mode, correction off: data writes followed by an update trigger.
// RULE_07: Sync with correction on: trigger waits until correction completes.
// RULE_08: Update comes from load pin pulse or the software load bit.
// RULE_09: Data lines two-way: host drives on writes, device on reads.
// RULE_10: Same-address writes keep chip select rising edges spaced apart.
// RULE_11: Device drives data only during selected reads, else released.
module octal_port_host #(
  parameter int ADDR_W = octal_port_pkg::ADDR_W,
  parameter int DATA_W = octal_port_pkg::DATA_W
) (
  input  wire logic                 clock_in,
  input  wire logic                 sys_rst_in,
  input  wire logic [3:0]           reg_addr_in,
  input  wire logic [31:0]          reg_wdata_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  output logic [31:0]               reg_rdata_out,
  output logic                      rd_not_wr_out,
  output logic                      chip_sel_n_out,
  output logic                      load_outputs_n_out,
  output logic [ADDR_W-1:0]         dev_addr_out,
  output logic [DATA_W-1:0]         dev_data_out,
  output logic [DATA_W-1:0]         dev_data_oe_out,
  input  wire logic [DATA_W-1:0]    dev_data_in,
  input  wire logic                 busy_n_in
);
  import octal_port_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_GAP, ST_WAIT_BUSY, ST_LOAD, ST_SPACE
  } state_e;

  state_e                state_r, state_nxt;
  logic [CNT_W-1:0]      cnt_r, cnt_nxt;
  logic [ADDR_W-1:0]     addr_r;
  logic [DATA_W-1:0]     wdata_r, rdata_r, din_s1_r, din_s2_r;
  logic                  busy_s1_r, busy_s2_r;
  logic                  read_r, sync_r, corr_r, swload_r;
  logic                  busy_flag_r, done_r;
  logic [31:0]           reg_rdata_r;
  logic                  go_w, strobe_low_w, drive_w, load_low_w, read_eff_w;
  seq_e                  seq_w;
  logic [31:0]           rd_mux_w;

  // Command decode
  assign go_w = reg_wr_in && (reg_addr_in == REG_CTRL) && reg_wdata_in[CTRL_GO_BIT]
                && (state_r == ST_IDLE);
  assign seq_w = !sync_r ? SEQ_DIRECT : (corr_r ? SEQ_SYNC_CORR : SEQ_SYNC);
  // Pin decode from the next state; a go takes its direction straight off the bus,
  // so a read never drives the data lines in its first setup cycle
  assign read_eff_w   = go_w ? reg_wdata_in[CTRL_READ_BIT] : read_r; // RULE_01
  assign strobe_low_w = (state_nxt == ST_STROBE); // RULE_02
  assign drive_w      = !read_eff_w && (state_nxt == ST_SETUP || state_nxt == ST_STROBE ||
                                        state_nxt == ST_HOLD); // RULE_09 RULE_11
  assign load_low_w   = ((state_nxt == ST_LOAD) && !swload_r) || !sync_r; // RULE_05 RULE_08
  assign rd_mux_w = (reg_addr_in == REG_ADDR)   ? {{(32-ADDR_W){1'b0}}, addr_r} :
                    (reg_addr_in == REG_WDATA)  ? {{(32-DATA_W){1'b0}}, wdata_r} :
                    (reg_addr_in == REG_CTRL)   ? {27'h0, swload_r, corr_r, sync_r,
                                                   read_r, 1'b0} :
                    (reg_addr_in == REG_STATUS) ? {29'h0, busy_s2_r, done_r,
                                                   busy_flag_r} :
                    (reg_addr_in == REG_RDATA)  ? {{(32-DATA_W){1'b0}}, rdata_r} :
                    RESET_WORD;

  // Pin synchronisers
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      din_s1_r  <= '0;
      din_s2_r  <= '0;
      busy_s1_r <= 1'b1;
      busy_s2_r <= 1'b1;
    end else begin
      din_s1_r  <= dev_data_in;
      din_s2_r  <= din_s1_r;
      busy_s1_r <= busy_n_in;
      busy_s2_r <= busy_s1_r;
    end
  end

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
    unique case (state_r)
      ST_IDLE: begin
        if (go_w) begin
          state_nxt = ST_SETUP;
          cnt_nxt   = CNT_W'(SETUP_CYC - 1);
        end
      end
      ST_SETUP: begin
        if (cnt_r == '0) begin
          state_nxt = ST_STROBE;
          cnt_nxt   = read_r ? CNT_W'(CS_RD_CYC - 1) : CNT_W'(CS_WR_CYC - 1);
        end
      end
      ST_STROBE: begin
        if (cnt_r == '0) begin
          state_nxt = ST_HOLD;
          cnt_nxt   = CNT_W'(HOLD_CYC - 1);
        end
      end
      ST_HOLD: begin
        if (cnt_r == '0) begin
          if (read_r || seq_w == SEQ_DIRECT) begin // RULE_04 RULE_05
            state_nxt = ST_SPACE;
            cnt_nxt   = CNT_W'(SAME_CYC - 1); // RULE_10
          end else begin
            state_nxt = ST_GAP; // RULE_06
            cnt_nxt   = CNT_W'(CS_LOAD_CYC - 1);
          end
        end
      end
      ST_GAP: begin
        if (cnt_r == '0) begin
          if (seq_w == SEQ_SYNC_CORR) begin
            state_nxt = ST_WAIT_BUSY; // RULE_07
            cnt_nxt   = CNT_W'(BUSY_CYC + 2);
          end else begin
            state_nxt = ST_LOAD;
            cnt_nxt   = CNT_W'(LOAD_CYC - 1);
          end
        end
      end
      ST_WAIT_BUSY: begin
        // Count covers busy fall latency plus synchroniser delay
        if (cnt_r == '0 && busy_s2_r) begin // RULE_07
          state_nxt = ST_LOAD;
          cnt_nxt   = CNT_W'(LOAD_CYC - 1);
        end
      end
      ST_LOAD: begin
        if (cnt_r == '0) begin
          state_nxt = ST_SPACE;
          cnt_nxt   = CNT_W'(SAME_CYC - 1);
        end
      end
      ST_SPACE: begin
        if (cnt_r == '0) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // Command registers; swload selects software trigger instead of pin pulse
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      addr_r           <= '0;
      wdata_r          <= '0;
      read_r           <= 1'b0;
      sync_r           <= 1'b0;
      corr_r           <= 1'b0;
      swload_r         <= 1'b0;
    end else if (reg_wr_in && state_r == ST_IDLE) begin
      if (reg_addr_in == REG_ADDR)
        addr_r <= reg_wdata_in[ADDR_W-1:0];
      if (reg_addr_in == REG_WDATA)
        wdata_r <= reg_wdata_in[DATA_W-1:0];
      if (reg_addr_in == REG_CTRL) begin
        read_r   <= reg_wdata_in[CTRL_READ_BIT]; // RULE_01
        sync_r   <= reg_wdata_in[CTRL_SYNC_BIT];
        corr_r   <= reg_wdata_in[CTRL_CORR_BIT];
        swload_r <= reg_wdata_in[CTRL_LOAD_BIT]; // RULE_08
      end
    end
  end

  // Status and read capture; done set wins over read clear
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_r        <= '0;
      busy_flag_r    <= 1'b0;
      done_r         <= 1'b0;
    end else begin
      if (state_r == ST_STROBE && cnt_r == '0 && read_r)
        rdata_r <= din_s2_r;
      busy_flag_r <= (state_nxt != ST_IDLE);
      if (state_r == ST_SPACE && cnt_r == '0)
        done_r <= 1'b1;
      else if (reg_rd_in && reg_addr_in == REG_STATUS)
        done_r <= 1'b0;
    end
  end

  // Pin and read-data outputs, all registered
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out      <= RESET_WORD;
      rd_not_wr_out      <= 1'b1;
      chip_sel_n_out     <= 1'b1;
      load_outputs_n_out <= 1'b1;
      dev_addr_out       <= '0;
      dev_data_out       <= '0;
      dev_data_oe_out    <= '0;
    end else begin
      reg_rdata_out      <= reg_rd_in ? rd_mux_w : RESET_WORD;
      rd_not_wr_out      <= (state_nxt == ST_IDLE) ? 1'b1 : read_eff_w; // RULE_01
      chip_sel_n_out     <= !strobe_low_w; // RULE_02
      load_outputs_n_out <= !load_low_w; // RULE_05 RULE_08
      dev_addr_out       <= addr_r;
      dev_data_out       <= wdata_r;
      dev_data_oe_out    <= {DATA_W{drive_w}}; // RULE_09
    end
  end
endmodule

/* octal_port_host_assertions.sv */
// Checker for the octal port host pins and register port
`timescale 1ns/1ps
module octal_port_host_assertions (
  input wire logic        clock_in,
  input wire logic        sys_rst_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        rd_not_wr_out,
  input wire logic        chip_sel_n_out,
  input wire logic        load_outputs_n_out,
  input wire logic [11:0] dev_data_out,
  input wire logic [11:0] dev_data_oe_out,
  input wire logic        busy_n_in
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  // Select low spans: write five cycles, read eight
  sequence s_wr_low; !chip_sel_n_out[*5] ##1 chip_sel_n_out; endsequence
  sequence s_rd_low; !chip_sel_n_out[*8] ##1 chip_sel_n_out; endsequence
  chk_wr_width: assert property ($fell(chip_sel_n_out) && !rd_not_wr_out |-> s_wr_low)
    else $error("write select width wrong");
  chk_rd_width: assert property ($fell(chip_sel_n_out) && rd_not_wr_out |-> s_rd_low)
    else $error("read select width wrong");
  chk_oe_write_only: assert property (|dev_data_oe_out |-> !rd_not_wr_out)
    else $error("data driven during read");
  chk_wr_data_held: assert property (!chip_sel_n_out && !rd_not_wr_out
    |-> &dev_data_oe_out && $stable(dev_data_out)) else $error("write data not held");
  chk_cs_spacing: assert property ($rose(chip_sel_n_out) |-> chip_sel_n_out[*5])
    else $error("select rises too close");
  chk_load_quiet: assert property ($rose(chip_sel_n_out) |-> $stable(load_outputs_n_out)[*4])
    else $error("load too soon after select");
  // Busy passes two sync stages before the host may see it high
  chk_load_busy: assert property ($fell(load_outputs_n_out) |-> $past(busy_n_in, 3))
    else $error("load issued while busy");
  chk_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data outside slot");
endmodule

bind octal_port_host octal_port_host_assertions u_chk (.*);

/* octal_dev_model.sv */
// Behavioural converter model on the far side of the parallel port
`timescale 1ns/1ps
module octal_dev_model (
  input  wire logic        clock_in,
  input  wire logic        rd_not_wr_in,
  input  wire logic        chip_sel_n_in,
  input  wire logic        load_outputs_n_in,
  input  wire logic [4:0]  addr_in,
  input  wire logic [11:0] data_in,
  input  wire logic        corr_in,
  output logic [11:0]      data_out,
  output logic             busy_n_out
);
  logic [11:0] mem [0:31];
  logic [11:0] last_r = 12'h0;
  logic        cs_q   = 1'b1;
  int          busy_cnt = 0;
  int          loads    = 0;
  // Released lines toggle so a stale value never looks valid
  assign data_out   = (!chip_sel_n_in && rd_not_wr_in) ? mem[addr_in] : ~last_r;
  assign busy_n_out = (busy_cnt == 0);
  // Channels 0-3 and 4-7 live in one word array
  always @(posedge clock_in) begin
    cs_q   <= chip_sel_n_in;
    last_r <= data_out;
    if (!chip_sel_n_in && !rd_not_wr_in) mem[addr_in] <= data_in;
    if (chip_sel_n_in && !cs_q && corr_in) busy_cnt <= 10;
    else if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
  end
  // One update per falling load edge
  always @(negedge load_outputs_n_in) loads++;
endmodule

/* test_octal_port_host.sv */
// Self-checking bench for the octal port host
`timescale 1ns/1ps
module test_octal_port_host;
  import octal_port_pkg::*;
  logic        clock_in = 0, sys_rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, corr_on = 0;
  logic [3:0]  reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, rd_v;
  logic        rd_not_wr_out, chip_sel_n_out, load_outputs_n_out, busy_n;
  logic [4:0]  dev_addr_out;
  logic [11:0] dev_data_out, dev_data_oe_out, dev_q, bus;
  int          num_errors = 0, checks_done = 0, l0;
  // Wire level from both drivers
  assign bus = (dev_data_oe_out & dev_data_out) | (~dev_data_oe_out & dev_q);
  octal_port_host DUT (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .rd_not_wr_out(rd_not_wr_out), .chip_sel_n_out(chip_sel_n_out),
    .load_outputs_n_out(load_outputs_n_out), .dev_addr_out(dev_addr_out),
    .dev_data_out(dev_data_out), .dev_data_oe_out(dev_data_oe_out), .dev_data_in(bus),
    .busy_n_in(busy_n));
  octal_dev_model M (.clock_in(clock_in), .rd_not_wr_in(rd_not_wr_out),
    .chip_sel_n_in(chip_sel_n_out), .load_outputs_n_in(load_outputs_n_out),
    .addr_in(dev_addr_out), .data_in(bus), .corr_in(corr_on), .data_out(dev_q),
    .busy_n_out(busy_n));
  initial begin
    forever #4 clock_in = ~clock_in;
  end
  task automatic end_sim();
    if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge clock_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(logic [3:0] a);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1 rd_v = reg_rdata_out;
  endtask
  // One device access, then bounded poll of the sticky done bit
  task automatic go(logic [4:0] a, logic [11:0] d, logic [31:0] c);
    int n;
    wr(REG_ADDR, {27'h0, a});
    wr(REG_WDATA, {20'h0, d});
    wr(REG_CTRL, c | 32'h1);
    n = 0;
    do begin
      rd(REG_STATUS);
      n++;
    end while (rd_v[1] !== 1'b1 && n < 200);
    if (rd_v[1] !== 1'b1) begin
      num_errors++;
      end_sim();
    end
  endtask
  task automatic t_idle();
    #1;
    chk("cs_n", chip_sel_n_out, 1);
    chk("load_n", load_outputs_n_out, 0);
    chk("oe", dev_data_oe_out, 0);
  endtask
  // Every channel of both groups, then a same-address repeat
  task automatic t_direct();
    l0 = M.loads;
    for (int i = 0; i < 8; i++) begin
      go(i[4:0], 12'hA50 + i[11:0], 32'h0);
      chk("chan", M.mem[i], 12'hA50 + i[11:0]);
    end
    go(5'h10, 12'h3C3, 32'h0);
    go(5'h10, 12'hC3C, 32'h0);
    chk("aux", M.mem[16], 12'hC3C);
    chk("no load", M.loads, l0);
  endtask
  task automatic t_read();
    go(5'h3, 12'h0, 32'h2);
    rd(REG_RDATA);
    chk("rdata", rd_v, 32'hA53);
    rd(4'hF);
    chk("unmapped", rd_v, 0);
    rd(REG_ADDR);
    chk("addr back", rd_v, 32'h3);
    rd(REG_CTRL);
    chk("ctrl back", rd_v, 32'h2);
    rd(REG_STATUS);
    chk("done clr", rd_v[1], 0);
    chk("status", rd_v, 32'h4);
  endtask
  task automatic t_sync();
    l0 = M.loads;
    go(5'h5, 12'hFFF, 32'h4);
    chk("sync data", M.mem[5], 12'hFFF);
    chk("sync load", M.loads, l0 + 1);
    go(5'h6, 12'h001, 32'h14);
    chk("sw load", M.loads, l0 + 1);
  endtask
  // Device stays busy after the write; the pulse must wait it out
  task automatic t_corr();
    corr_on <= 1'b1;
    l0 = M.loads;
    go(5'h7, 12'h800, 32'hC);
    chk("corr load", M.loads, l0 + 1);
    chk("busy done", busy_n, 1);
    corr_on <= 1'b0;
  endtask
  initial begin
    repeat (20) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    t_idle();
    t_direct();
    t_read();
    t_sync();
    t_corr();
    end_sim();
  end
endmodule
